//--- hw/csm_pkg.sv
package csm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 250_000_000;
    localparam int QUAL_LONG_US    = 1000;
    localparam int QUAL_SHORT_US   = 100;
    localparam int RETRY_LONG_MS   = 50;
    localparam int RETRY_SHORT_MS  = 10;
    localparam int QUAL_LONG_CYC   = QUAL_LONG_US * (CLK_HZ / 1_000_000);
    localparam int QUAL_SHORT_CYC  = QUAL_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int RETRY_LONG_CYC  = RETRY_LONG_MS * (CLK_HZ / 1_000);
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_MS * (CLK_HZ / 1_000);
    localparam int TIMER_W         = 24;

    // ------------------------------------------------------------
    // Slave address
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_BASE = 7'h70;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CONTROL_OFS   = 8'h0A;
    localparam logic [7:0] TIMING_CONTROL_OFS = 8'h0B;
    localparam logic [7:0] MODE_CONTROL_RST   = 8'h00;
    localparam logic [7:0] TIMING_CONTROL_RST = 8'h00;
    localparam int         LATCH_CLEAR_POS    = 4;
    localparam int         QUAL_SEL_POS       = 3;
    localparam int         RETRY_SEL_POS      = 2;
    localparam logic [7:0] TIMING_WMASK       = 8'h0C;
    localparam logic [2:0] MODE_NORMAL        = 3'b000;
    localparam logic [2:0] MODE_AMP_RETRY     = 3'b011;
    localparam logic [2:0] MODE_CMP_RETRY     = 3'b111;
    localparam logic [7:0] READ_FILL          = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } csm_state_type;

    typedef enum logic [1:0] {
        FL_QUALIFY,
        FL_LATCHED
    } csm_fault_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } csm_bus_in_type;

endpackage

//--- hw/csm_top.sv
`timescale 1ns/1ps
module csm_top
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Serial bus, open drain
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Address straps, four levels each
    input  wire logic [1:0] address_strap_upper,
    input  wire logic [1:0] address_strap_lower,
    // Analog comparison result
    input  wire logic       sense_amp_result,
    // Output stage control
    output logic            output_assert,
    output logic            amp_select,
    output logic            fault_latched
);

    // ------------------------------------------------------------
    // Bus sampling and condition detect
    // ------------------------------------------------------------
    csm_pkg::csm_bus_in_type bus_r;
    csm_pkg::csm_bus_in_type bus_d_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bus_r   <= '{scl: 1'b1, sda: 1'b1};
            bus_d_r <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            bus_r   <= '{scl: scl_in, sda: sda_in};
            bus_d_r <= bus_r;
        end
    end

    wire scl_rise  = bus_r.scl & ~bus_d_r.scl;
    wire scl_fall  = ~bus_r.scl & bus_d_r.scl;
    wire start_det = bus_r.scl & bus_d_r.scl & ~bus_r.sda & bus_d_r.sda;
    wire stop_det  = bus_r.scl & bus_d_r.scl & bus_r.sda & ~bus_d_r.sda;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [6:0] own_addr = csm_pkg::SLAVE_BASE
                        | {3'b000, address_strap_upper, address_strap_lower};

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    csm_pkg::csm_state_type state_r;
    csm_pkg::csm_state_type state_nxt;
    logic [7:0] shift_r;
    logic [2:0] bitcnt_r;
    logic [7:0] ptr_r;
    logic       ptr_loaded_r;
    logic       reading_r;
    logic       sda_low_r;
    logic [7:0] mode_r;
    logic [7:0] timing_r;

    wire [7:0] shift_nxt   = {shift_r[6:0], bus_r.sda};
    wire       byte_done   = scl_rise & (bitcnt_r == 3'd7);
    wire       addr_match  = (shift_nxt[7:1] == own_addr);
    wire [7:0] rd_data     = (ptr_r == csm_pkg::MODE_CONTROL_OFS)   ? mode_r
                           : (ptr_r == csm_pkg::TIMING_CONTROL_OFS) ? timing_r
                           : csm_pkg::READ_FILL;
    wire       wr_strobe   = (state_r == csm_pkg::ST_WRITE) & byte_done & ptr_loaded_r;
    wire       ptr_strobe  = (state_r == csm_pkg::ST_WRITE) & byte_done & ~ptr_loaded_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            csm_pkg::ST_IDLE: ;
            csm_pkg::ST_ADDR:
                if (byte_done)
                    state_nxt = addr_match ? csm_pkg::ST_ADDR_ACK : csm_pkg::ST_IDLE;
            // Leave on the fall that ends the ACK clock, not the one ending bit 8
            csm_pkg::ST_ADDR_ACK:
                if (scl_fall & (bitcnt_r == 3'd1))
                    state_nxt = reading_r ? csm_pkg::ST_READ : csm_pkg::ST_WRITE;
            csm_pkg::ST_WRITE:
                if (byte_done)
                    state_nxt = csm_pkg::ST_WRITE_ACK;
            csm_pkg::ST_WRITE_ACK:
                if (scl_fall & (bitcnt_r == 3'd1))
                    state_nxt = csm_pkg::ST_WRITE;
            csm_pkg::ST_READ:
                if (scl_fall & (bitcnt_r == 3'd7))
                    state_nxt = csm_pkg::ST_READ_ACK;
            // Next byte starts after the ACK clock falls, so its MSB gets a full bit time
            csm_pkg::ST_READ_ACK:
                if (scl_rise & bus_r.sda)
                    state_nxt = csm_pkg::ST_IDLE;
                else if (scl_fall)
                    state_nxt = csm_pkg::ST_READ;
            default:
                state_nxt = csm_pkg::ST_IDLE;
        endcase
        if (start_det)
            state_nxt = csm_pkg::ST_ADDR;
        else if (stop_det)
            state_nxt = csm_pkg::ST_IDLE;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            state_r <= csm_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Bit counter: counts SCL falls while sending read data in ST_READ, SCL rises in every other state
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bitcnt_r <= 3'd0;
        else if (start_det || state_nxt != state_r)
            bitcnt_r <= 3'd0;
        else if ((state_r == csm_pkg::ST_READ) ? scl_fall : scl_rise)
            bitcnt_r <= bitcnt_r + 3'd1;
    end

    // Sampled on SCL rise; master clocks everything, so slow sampling suffices
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            shift_r <= 8'h00;
        else if (state_r == csm_pkg::ST_ADDR_ACK && state_nxt == csm_pkg::ST_READ)
            shift_r <= rd_data;
        else if (state_r == csm_pkg::ST_READ_ACK && state_nxt == csm_pkg::ST_READ)
            shift_r <= rd_data;
        else if (state_r == csm_pkg::ST_READ && scl_fall)
            shift_r <= {shift_r[6:0], 1'b0};
        else if (scl_rise && state_r != csm_pkg::ST_READ)
            shift_r <= shift_nxt;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reading_r    <= 1'b0;
            ptr_loaded_r <= 1'b0;
            ptr_r        <= 8'h00;
        end
        else
        begin
            if (state_r == csm_pkg::ST_ADDR && byte_done)
                reading_r <= shift_nxt[0];
            if (start_det)
                ptr_loaded_r <= 1'b0;
            else if (ptr_strobe)
                ptr_loaded_r <= 1'b1;
            if (ptr_strobe)
                ptr_r <= shift_nxt;
            else if (wr_strobe)
                ptr_r <= ptr_r + 8'h01;
            // Step at end of byte so the next load fetches the next register
            else if (state_r == csm_pkg::ST_READ && state_nxt == csm_pkg::ST_READ_ACK)
                ptr_r <= ptr_r + 8'h01;
        end
    end

    // ACK pull starts only once SCL is low and ends with the state, never forming START or STOP
    wire drive_ack = (state_r == csm_pkg::ST_ADDR_ACK) | (state_r == csm_pkg::ST_WRITE_ACK);
    wire drive_low = (drive_ack & sda_low_r) | ((state_r == csm_pkg::ST_READ) & ~shift_r[7]);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sda_low_r <= 1'b0;
        else if (drive_ack && !sda_low_r && !bus_r.scl)
            sda_low_r <= 1'b1;
        else if (!drive_ack)
            sda_low_r <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sda_oe_n <= 1'b1;
        else
            sda_oe_n <= ~(drive_low & (state_nxt == state_r));
    end

    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    wire wr_mode   = wr_strobe & (ptr_r == csm_pkg::MODE_CONTROL_OFS);
    wire wr_timing = wr_strobe & (ptr_r == csm_pkg::TIMING_CONTROL_OFS);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mode_r   <= csm_pkg::MODE_CONTROL_RST;
            timing_r <= csm_pkg::TIMING_CONTROL_RST;
        end
        else
        begin
            if (wr_mode)
                mode_r <= shift_nxt;
            else
                mode_r[csm_pkg::LATCH_CLEAR_POS] <= 1'b0;
            if (wr_timing)
                timing_r <= shift_nxt & csm_pkg::TIMING_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Qualify, latch and retry
    // ------------------------------------------------------------
    wire [2:0] mode_field  = mode_r[7:5];
    wire       retry_mode  = (mode_field == csm_pkg::MODE_CMP_RETRY)
                           | (mode_field == csm_pkg::MODE_AMP_RETRY);
    wire       latch_clear = mode_r[csm_pkg::LATCH_CLEAR_POS];
    wire [csm_pkg::TIMER_W-1:0] qual_lim = timing_r[csm_pkg::QUAL_SEL_POS]
        ? csm_pkg::TIMER_W'(csm_pkg::QUAL_SHORT_CYC - 1)
        : csm_pkg::TIMER_W'(csm_pkg::QUAL_LONG_CYC - 1);
    wire [csm_pkg::TIMER_W-1:0] retry_lim = timing_r[csm_pkg::RETRY_SEL_POS]
        ? csm_pkg::TIMER_W'(csm_pkg::RETRY_SHORT_CYC - 1)
        : csm_pkg::TIMER_W'(csm_pkg::RETRY_LONG_CYC - 1);

    csm_pkg::csm_fault_type     fault_r;
    logic [csm_pkg::TIMER_W-1:0] timer_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            fault_r <= csm_pkg::FL_QUALIFY;
            timer_r <= '0;
        end
        else if (!retry_mode || latch_clear)
        begin
            fault_r <= csm_pkg::FL_QUALIFY;
            timer_r <= '0;
        end
        else
        begin
            case (fault_r)
                csm_pkg::FL_QUALIFY:
                    if (!sense_amp_result)
                        timer_r <= '0;
                    else if (timer_r >= qual_lim)
                    begin
                        fault_r <= csm_pkg::FL_LATCHED;
                        timer_r <= '0;
                    end
                    else
                        timer_r <= timer_r + 1'b1;
                csm_pkg::FL_LATCHED:
                    if (timer_r >= retry_lim)
                    begin
                        fault_r <= csm_pkg::FL_QUALIFY;
                        timer_r <= '0;
                    end
                    else
                        timer_r <= timer_r + 1'b1;
                default:
                    fault_r <= csm_pkg::FL_QUALIFY;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            output_assert <= 1'b0;
            amp_select    <= 1'b0;
            fault_latched <= 1'b0;
        end
        else
        begin
            amp_select    <= ~mode_r[7];
            // Leaving retry mode or clearing drops the latch view at once
            fault_latched <= retry_mode & ~latch_clear & (fault_r == csm_pkg::FL_LATCHED);
            output_assert <= retry_mode ? (~latch_clear & (fault_r == csm_pkg::FL_LATCHED))
                                        : sense_amp_result;
        end
    end

endmodule // csm_top

//--- tb/csm_checker.sv
`timescale 1ns/1ps
module csm_checker
(
    // Watched ports
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic [1:0] address_strap_upper,
    input wire logic [1:0] address_strap_lower,
    input wire logic       sense_amp_result,
    input wire logic       output_assert,
    input wire logic       amp_select,
    input wire logic       fault_latched
);
    // Short delay is the floor, so long delay is only loosely bounded
    localparam int QUAL_MIN = csm_pkg::QUAL_SHORT_CYC - 4;
    logic [23:0] hi_cnt_r;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            hi_cnt_r <= 24'h000000;
        else if (!sense_amp_result)
            hi_cnt_r <= 24'h000000;
        else if (!(&hi_cnt_r))
            hi_cnt_r <= hi_cnt_r + 24'h000001;
    end
    a_sda_low_only: assert property (@(posedge clock) sda_out == 1'b0)
        else $error("sda_out driven high");
    // First edge of reset is skipped: outputs are still unknown before it
    a_reset_quiet: assert property (@(posedge clock) rst ##1 rst |-> sda_oe_n && !output_assert && !fault_latched)
        else $error("outputs active in reset");
    a_amp_after_reset: assert property (@(posedge clock) $fell(rst) |-> !amp_select ##1 amp_select)
        else $error("op-amp not selected after reset");
    a_latch_drives_out: assert property (@(posedge clock) disable iff (rst) fault_latched |-> output_assert)
        else $error("latched state not on output");
    a_latch_after_qual: assert property (@(posedge clock) disable iff (rst)
        $rose(fault_latched) |-> hi_cnt_r >= QUAL_MIN)
        else $error("latched before qualify delay");
    a_sda_moves_low: assert property (@(posedge clock) disable iff (rst)
        $changed(sda_oe_n) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
        else $error("sda changed while scl high");
    a_ack_stands: assert property (@(posedge clock) disable iff (rst) $fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("sda pull too short");
    a_out_rise_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(output_assert) |-> $past(sense_amp_result) || fault_latched)
        else $error("output rose without cause");
endmodule // csm_checker
bind csm_top csm_checker chk_u (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_strap_upper(address_strap_upper), .address_strap_lower(address_strap_lower),
    .sense_amp_result(sense_amp_result), .output_assert(output_assert), .amp_select(amp_select),
    .fault_latched(fault_latched));

//--- tb/csm_master.sv
`timescale 1ns/1ps
module csm_master
(
    // Bus
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    localparam int HALF = 10;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Data moves two clocks after scl falls, never with it
    task automatic start();
        tick(2);
        sda_m <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_m <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_m <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_m <= 1'b1;
        tick(HALF);
    endtask
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            tick(2);
            sda_m <= tx[i];
            tick(HALF);
            scl <= 1'b1;
            tick(HALF / 2);
            rx[i] = sda;
            tick(HALF / 2);
            scl <= 1'b0;
        end
    endtask
endmodule // csm_master

//--- tb/csm_top_tb.sv
`timescale 1ns/1ps
module csm_top_tb;
    localparam int QS = csm_pkg::QUAL_SHORT_CYC;
    logic       clock = 1'b0;
    logic       rst   = 1'b1;
    logic [3:0] strap = 4'h0;
    logic       sense = 1'b0;
    logic       scl;
    logic       sda_m;
    logic       sda_out;
    logic       sda_oe_n;
    logic       output_assert;
    logic       amp_select;
    logic       fault_latched;
    logic [7:0] lf = 8'h58;
    logic [7:0] rd[2];
    logic [7:0] v;
    logic [7:0] t;
    int         failures = 0;
    int         n_tests = 0;
    // Pull-up on the wire
    wire logic  sda = sda_m & (sda_oe_n | sda_out);
    always #2 clock = ~clock;
    csm_top dut_u (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_strap_upper(strap[3:2]), .address_strap_lower(strap[1:0]), .sense_amp_result(sense),
        .output_assert(output_assert), .amp_select(amp_select), .fault_latched(fault_latched));
    csm_master master_u (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] dev_addr();
        return 8'hE0 + {3'h0, strap, 1'b0};
    endfunction
    task automatic summarize();
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic addr_phase(input logic [7:0] adr, input logic ack);
        logic [8:0] rx;
        master_u.start();
        master_u.xfer({adr, 1'b1}, rx);
        chk({7'h00, ~rx[0]}, {7'h00, ack});
    endtask
    task automatic send(input logic [7:0] d);
        logic [8:0] rx;
        master_u.xfer({d, 1'b1}, rx);
        chk({7'h00, ~rx[0]}, 8'h01);
    endtask
    task automatic reg_write(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b, input logic two);
        addr_phase(dev_addr(), 1'b1);
        send(p);
        send(a);
        if (two)
            send(b);
        master_u.stop();
    endtask
    task automatic reg_read(input logic [7:0] p, input int n);
        logic [8:0] rx;
        addr_phase(dev_addr(), 1'b1);
        send(p);
        addr_phase(dev_addr() | 8'h01, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            master_u.xfer({8'hFF, i == n - 1}, rx);
            rd[i] = rx[8:1];
        end
        master_u.stop();
    endtask
    task automatic wait_latch(input int lim);
        int i;
        for (i = 0; i < lim && fault_latched !== 1'b1; i++)
            @(posedge clock);
        if (i == lim)
        begin
            failures++;
            summarize();
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        chk({7'h00, amp_select}, 8'h01);
        reg_read(8'h0A, 2);
        chk(rd[0], 8'h00);
        chk(rd[1], 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            strap <= i[3:0];
            @(posedge clock);
            addr_phase(dev_addr() ^ 8'h10, 1'b0);
            master_u.stop();
            addr_phase(dev_addr(), 1'b1);
            master_u.stop();
        end
        lf = lfsr_next(lf);
        strap <= lf[3:0];
        v = lf & 8'h0F;
        t = lfsr_next(lf);
        @(posedge clock);
        reg_write(8'h0A, v, t, 1'b1);
        reg_read(8'h0A, 2);
        chk(rd[0], v);
        chk(rd[1], t & 8'h0C);
        for (int i = 0; i < 8; i++)
        begin
            lf = lfsr_next(lf);
            sense <= lf[0];
            repeat (3) @(posedge clock);
            chk({7'h00, output_assert}, {7'h00, lf[0]});
        end
        reg_write(8'h0A, 8'h80, 8'h00, 1'b0);
        chk({7'h00, amp_select}, 8'h00);
        sense <= 1'b0;
        reg_write(8'h0B, 8'h08, 8'h00, 1'b0);
        reg_write(8'h0A, 8'hE0, 8'h00, 1'b0);
        sense <= 1'b1;
        repeat (QS - 100) @(posedge clock);
        chk({7'h00, fault_latched}, 8'h00);
        wait_latch(300);
        chk({7'h00, output_assert}, 8'h01);
        reg_write(8'h0A, 8'hF0, 8'h00, 1'b0);
        chk({7'h00, fault_latched}, 8'h00);
        reg_read(8'h0A, 1);
        chk(rd[0], 8'hE0);
        sense <= 1'b0;
        reg_write(8'h0A, 8'h60, 8'h00, 1'b0);
        chk({7'h00, amp_select}, 8'h01);
        sense <= 1'b1;
        wait_latch(QS + 300);
        chk({7'h00, output_assert}, 8'h01);
        summarize();
    end
endmodule // csm_top_tb
